// ==== rtl/pcc_pkg.sv ====
/*
 * Shared constants and types of the pixel colour convert and lookup block.
 * Assumes a single 100 MHz clock and an active-low asynchronous reset.
 */
package pcc_pkg;

   // Sample and table geometry
   localparam int PCC_PIX_W   = 16;
   localparam int PCC_IDX_W   = 14;
   localparam int PCC_DEPTH   = 16384;
   localparam int PCC_NCOMP   = 3;

   // Register offsets (byte addresses)
   localparam logic [7:0] PCC_OFF_CTRL     = 8'h00;
   localparam logic [7:0] PCC_OFF_RED_IDX  = 8'h04;
   localparam logic [7:0] PCC_OFF_RED_VAL  = 8'h08;
   localparam logic [7:0] PCC_OFF_GRN_IDX  = 8'h0c;
   localparam logic [7:0] PCC_OFF_GRN_VAL  = 8'h10;
   localparam logic [7:0] PCC_OFF_BLU_IDX  = 8'h14;
   localparam logic [7:0] PCC_OFF_BLU_VAL  = 8'h18;
   localparam logic [7:0] PCC_OFF_GEN_IDX  = 8'h1c;
   localparam logic [7:0] PCC_OFF_GEN_VAL  = 8'h20;
   localparam logic [7:0] PCC_OFF_STATUS   = 8'h24;

   // Control field positions
   localparam int PCC_CTRL_EN_BIT   = 0;
   localparam int PCC_CTRL_SRC_BIT  = 1;
   localparam int PCC_CTRL_IFMT_LSB = 2;
   localparam int PCC_CTRL_OFMT_LSB = 4;

   // Reset values
   localparam logic       PCC_RST_EN   = 1'b0;
   localparam logic       PCC_RST_SRC  = 1'b0;
   localparam logic [1:0] PCC_RST_FMT  = 2'h1;

   // Table source values
   localparam logic PCC_SRC_PROC = 1'b0;
   localparam logic PCC_SRC_FILE = 1'b1;

   // Pixel formats
   localparam logic [1:0] PCC_FMT_MONO  = 2'h0;
   localparam logic [1:0] PCC_FMT_RGB   = 2'h1;
   localparam logic [1:0] PCC_FMT_BAYER = 2'h2;
   localparam logic [1:0] PCC_FMT_YCC   = 2'h3;

   typedef struct packed {
      logic [PCC_PIX_W-1:0] c2;
      logic [PCC_PIX_W-1:0] c1;
      logic [PCC_PIX_W-1:0] c0;
   } pcc_pixel_t;

   typedef struct packed {
      logic                 valid;
      logic                 src;
      logic [1:0]           comp;
      logic [PCC_IDX_W-1:0] index;
      logic [PCC_PIX_W-1:0] data;
   } pcc_load_t;

endpackage : pcc_pkg

// ==== rtl/pcc_convert_lut.sv ====
/*
 * Colour format converter followed by three per-component lookup tables
 * and a two-entry output buffer.
 * Assumes upstream de-mosaic and downstream formatter run on CLK, and a
 * simple register port with read data one cycle after the read strobe.
 */
// Summary of operation
// - Each table is indexed by 14 bits, addresses 0 through 16383.
// - Samples are 16 bits wide; each entry holds a 16-bit value.
// - Index is the top 14 bits of the sample; low bits dropped.
// - Red, green, blue each have their own separate table.
// - Each component is replaced by its table entry at its index.
// - Table translation is the last step before the output stream.
// - Enable resets off; when off pixels bypass the table.
// - Source select is processor or custom file; resets to processor.
// - Host entry writes overwrite any stored entry in either mode.
// - Later loads from the selected source overwrite host-written entries.
// - 16384 read/write entries per table, reset to zero, via index.
// - Converter sits after de-mosaic, directly before the tables.
// - Converter pairs: RGB or Bayer to mono, and mono to RGB.
// - Conversion chosen from input and output formats automatically.
// - Unsupported format pairs pass pixels through unchanged.
// - Processor loads take effect only while processor source is set.
module pcc_convert_lut
   import pcc_pkg::*;
(
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        ARST_N,
   // Register port
   input  wire logic [7:0]  REG_ADDR,
   input  wire logic [31:0] REG_WDATA,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   output logic      [31:0] REG_RDATA,
   // Pixel input from de-mosaic
   input  wire logic        IN_VALID,
   output logic             IN_READY,
   input  wire pcc_pixel_t  IN_PIXEL,
   // Pixel output to formatter
   output logic             OUT_VALID,
   input  wire logic        OUT_READY,
   output pcc_pixel_t       OUT_PIXEL,
   // Table load from processor or file loader
   input  wire pcc_load_t   LOAD
);

   typedef struct packed {
      // Control fields
      logic                 en;
      logic                 src;
      logic [1:0]           ifmt;
      logic [1:0]           ofmt;
      // Host entry selectors
      logic [PCC_IDX_W-1:0] idx_r;
      logic [PCC_IDX_W-1:0] idx_g;
      logic [PCC_IDX_W-1:0] idx_b;
      // Output buffer
      pcc_pixel_t           buf0;
      pcc_pixel_t           buf1;
      logic                 wr_ptr;
      logic                 rd_ptr;
      logic [1:0]           count;
      // Read data and status
      logic [31:0]          rdata;
      logic [15:0]          pix_cnt;
   } pcc_state_t;

   pcc_state_t s_q;
   pcc_state_t s_d;

   // One table of 16-bit entries per component
   logic [PCC_PIX_W-1:0] tab_r [PCC_DEPTH];
   logic [PCC_PIX_W-1:0] tab_g [PCC_DEPTH];
   logic [PCC_PIX_W-1:0] tab_b [PCC_DEPTH];

   // Table write ports
   logic                 wr_r;
   logic                 wr_g;
   logic                 wr_b;
   logic [PCC_IDX_W-1:0] wa_r;
   logic [PCC_IDX_W-1:0] wa_g;
   logic [PCC_IDX_W-1:0] wa_b;
   logic [PCC_PIX_W-1:0] wd_r;
   logic [PCC_PIX_W-1:0] wd_g;
   logic [PCC_PIX_W-1:0] wd_b;
   // Stream datapath
   logic                 load_ok;
   logic                 push;
   logic                 pop;
   pcc_pixel_t           conv;
   pcc_pixel_t           mapped;

   // Table index from the most significant bits of a sample
   function automatic logic [PCC_IDX_W-1:0] idx_of(input logic [PCC_PIX_W-1:0] s);
      idx_of = s[PCC_PIX_W-1 -: PCC_IDX_W];
   endfunction : idx_of

   // Format conversion chosen from the configured pair
   function automatic pcc_pixel_t convert(input pcc_pixel_t p,
                                          input logic [1:0] ifmt,
                                          input logic [1:0] ofmt);
      logic [PCC_PIX_W+1:0] sum;
      sum     = '0;
      convert = p;
      if (ofmt == PCC_FMT_MONO &&
          (ifmt == PCC_FMT_RGB || ifmt == PCC_FMT_BAYER)) begin
         sum = {2'h0, p.c0} + {1'b0, p.c1, 1'b0} + {2'h0, p.c2};
         convert.c0 = sum[PCC_PIX_W+1:2];
         convert.c1 = sum[PCC_PIX_W+1:2];
         convert.c2 = sum[PCC_PIX_W+1:2];
      end else if (ofmt == PCC_FMT_RGB && ifmt == PCC_FMT_MONO) begin
         convert.c1 = p.c0;
         convert.c2 = p.c0;
      end
   endfunction : convert

   // Converter feeds the tables directly
   always_comb begin
      conv = convert(IN_PIXEL, s_q.ifmt, s_q.ofmt);
   end

   // Lookup, bypassed while disabled
   // Tables are read combinationally: a same-cycle write reaches the next pixel
   always_comb begin
      mapped = conv;
      if (s_q.en) begin
         mapped.c0 = tab_r[idx_of(conv.c0)];
         mapped.c1 = tab_g[idx_of(conv.c1)];
         mapped.c2 = tab_b[idx_of(conv.c2)];
      end
   end

   // Buffer handshake
   // Ready drops at two entries, so the fill level never passes two
   assign IN_READY  = (s_q.count != 2'h2);
   assign push      = IN_VALID && IN_READY;
   assign OUT_VALID = (s_q.count != 2'h0);
   assign pop       = OUT_VALID && OUT_READY;
   assign OUT_PIXEL = s_q.rd_ptr ? s_q.buf1 : s_q.buf0;
   assign REG_RDATA = s_q.rdata;

   // Load accepted only from the selected source
   assign load_ok = LOAD.valid && (LOAD.src == s_q.src);

   // Table write steering; host entry access wins a same-cycle clash
   always_comb begin
      wr_r = 1'b0;
      wr_g = 1'b0;
      wr_b = 1'b0;
      wa_r = LOAD.index;
      wa_g = LOAD.index;
      wa_b = LOAD.index;
      wd_r = LOAD.data;
      wd_g = LOAD.data;
      wd_b = LOAD.data;
      if (load_ok) begin
         wr_r = (LOAD.comp == 2'h0);
         wr_g = (LOAD.comp == 2'h1);
         wr_b = (LOAD.comp == 2'h2);
      end
      if (REG_WR) begin
         case (REG_ADDR)
            PCC_OFF_RED_VAL: begin
               wr_r = 1'b1;
               wa_r = s_q.idx_r;
               wd_r = REG_WDATA[PCC_PIX_W-1:0];
            end
            PCC_OFF_GRN_VAL: begin
               wr_g = 1'b1;
               wa_g = s_q.idx_g;
               wd_g = REG_WDATA[PCC_PIX_W-1:0];
            end
            PCC_OFF_BLU_VAL: begin
               wr_b = 1'b1;
               wa_b = s_q.idx_b;
               wd_b = REG_WDATA[PCC_PIX_W-1:0];
            end
            // Generic entry writes all three tables at the red index
            PCC_OFF_GEN_VAL: begin
               wr_r = 1'b1;
               wr_g = 1'b1;
               wr_b = 1'b1;
               wa_r = s_q.idx_r;
               wa_g = s_q.idx_r;
               wa_b = s_q.idx_r;
               wd_r = REG_WDATA[PCC_PIX_W-1:0];
               wd_g = REG_WDATA[PCC_PIX_W-1:0];
               wd_b = REG_WDATA[PCC_PIX_W-1:0];
            end
            default: begin
            end
         endcase
      end
   end

   // Tables: written in place, pixel stream never waits
   // Reset clears every entry, at the cost of a wide reset fan-out
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         for (int i = 0; i < PCC_DEPTH; i++) begin
            tab_r[i] <= '0;
            tab_g[i] <= '0;
            tab_b[i] <= '0;
         end
      end else begin
         if (wr_r) begin
            tab_r[wa_r] <= wd_r;
         end
         if (wr_g) begin
            tab_g[wa_g] <= wd_g;
         end
         if (wr_b) begin
            tab_b[wa_b] <= wd_b;
         end
      end
   end

   // Next state
   always_comb begin
      s_d = s_q;
      // Register writes
      if (REG_WR) begin
         case (REG_ADDR)
            PCC_OFF_CTRL: begin
               s_d.en   = REG_WDATA[PCC_CTRL_EN_BIT];
               s_d.src  = REG_WDATA[PCC_CTRL_SRC_BIT];
               s_d.ifmt = REG_WDATA[PCC_CTRL_IFMT_LSB +: 2];
               s_d.ofmt = REG_WDATA[PCC_CTRL_OFMT_LSB +: 2];
            end
            PCC_OFF_RED_IDX: s_d.idx_r = REG_WDATA[PCC_IDX_W-1:0];
            PCC_OFF_GRN_IDX: s_d.idx_g = REG_WDATA[PCC_IDX_W-1:0];
            PCC_OFF_BLU_IDX: s_d.idx_b = REG_WDATA[PCC_IDX_W-1:0];
            PCC_OFF_GEN_IDX: begin
               s_d.idx_r = REG_WDATA[PCC_IDX_W-1:0];
               s_d.idx_g = REG_WDATA[PCC_IDX_W-1:0];
               s_d.idx_b = REG_WDATA[PCC_IDX_W-1:0];
            end
            default: begin
            end
         endcase
      end
      // Register reads, data one cycle later
      s_d.rdata = '0;
      if (REG_RD) begin
         case (REG_ADDR)
            PCC_OFF_CTRL: begin
               s_d.rdata[PCC_CTRL_EN_BIT]        = s_q.en;
               s_d.rdata[PCC_CTRL_SRC_BIT]       = s_q.src;
               s_d.rdata[PCC_CTRL_IFMT_LSB +: 2] = s_q.ifmt;
               s_d.rdata[PCC_CTRL_OFMT_LSB +: 2] = s_q.ofmt;
            end
            PCC_OFF_RED_IDX: s_d.rdata[PCC_IDX_W-1:0] = s_q.idx_r;
            PCC_OFF_GRN_IDX: s_d.rdata[PCC_IDX_W-1:0] = s_q.idx_g;
            PCC_OFF_BLU_IDX: s_d.rdata[PCC_IDX_W-1:0] = s_q.idx_b;
            // Generic selector and entry read back the red view
            PCC_OFF_GEN_IDX: s_d.rdata[PCC_IDX_W-1:0] = s_q.idx_r;
            PCC_OFF_RED_VAL: s_d.rdata[PCC_PIX_W-1:0] = tab_r[s_q.idx_r];
            PCC_OFF_GRN_VAL: s_d.rdata[PCC_PIX_W-1:0] = tab_g[s_q.idx_g];
            PCC_OFF_BLU_VAL: s_d.rdata[PCC_PIX_W-1:0] = tab_b[s_q.idx_b];
            PCC_OFF_GEN_VAL: s_d.rdata[PCC_PIX_W-1:0] = tab_r[s_q.idx_r];
            PCC_OFF_STATUS: begin
               s_d.rdata[1:0]   = s_q.count;
               s_d.rdata[31:16] = s_q.pix_cnt;
            end
            default: s_d.rdata = '0;
         endcase
      end
      // Two-entry output buffer
      if (push) begin
         if (s_q.wr_ptr) begin
            s_d.buf1 = mapped;
         end else begin
            s_d.buf0 = mapped;
         end
         s_d.wr_ptr  = ~s_q.wr_ptr;
         s_d.pix_cnt = s_q.pix_cnt + 16'h0001;
      end
      if (pop) begin
         s_d.rd_ptr = ~s_q.rd_ptr;
      end
      // Push and pop together keep the fill level
      case ({push, pop})
         2'b10:   s_d.count = s_q.count + 2'h1;
         2'b01:   s_d.count = s_q.count - 2'h1;
         default: s_d.count = s_q.count;
      endcase
   end

   // State register
   // Formats reset to RGB in and out, which passes pixels unchanged
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         s_q      <= '0;
         s_q.en   <= PCC_RST_EN;
         s_q.src  <= PCC_RST_SRC;
         s_q.ifmt <= PCC_RST_FMT;
         s_q.ofmt <= PCC_RST_FMT;
      end else begin
         s_q <= s_d;
      end
   end

endmodule : pcc_convert_lut

// ==== testbench/pcc_convert_lut_monitor.sv ====
/* Checker of the pixel convert and lookup block.
   Assumes the package register map and the two-entry output buffer. */
module pcc_convert_lut_monitor
   import pcc_pkg::*;
(
   // Clock and reset
   input wire logic        CLK,
   input wire logic        ARST_N,
   // Register port
   input wire logic [7:0]  REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic        REG_WR,
   input wire logic        REG_RD,
   input wire logic [31:0] REG_RDATA,
   // Pixel stream
   input wire logic        IN_VALID,
   input wire logic        IN_READY,
   input wire pcc_pixel_t  IN_PIXEL,
   input wire logic        OUT_VALID,
   input wire logic        OUT_READY,
   input wire pcc_pixel_t  OUT_PIXEL
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] ctrl_q;
   logic       take;
   assign take = IN_VALID && IN_READY && !OUT_VALID;
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N)
         ctrl_q <= 6'h14;
      else if (REG_WR && REG_ADDR == PCC_OFF_CTRL)
         ctrl_q <= REG_WDATA[5:0];
   end
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!ARST_N);
   a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
      else $error("read data not zero outside answer");
   a_unmapped_zero: assert property ($past(REG_RD && REG_ADDR > 8'h24)
      |-> REG_RDATA == 32'h0)
      else $error("unmapped read not zero");
   a_upper_zero: assert property ($past(REG_RD && REG_ADDR != PCC_OFF_STATUS)
      |-> REG_RDATA[31:16] == 16'h0)
      else $error("upper read bits not zero");
   a_index_width: assert property ($past(REG_RD && REG_ADDR == PCC_OFF_RED_IDX)
      |-> REG_RDATA[31:14] == 18'h0)
      else $error("index wider than 14 bits");
   a_out_hold: assert property (OUT_VALID && !OUT_READY
      |=> OUT_VALID && $stable(OUT_PIXEL))
      else $error("output pixel dropped or changed");
   a_full_drain: assert property (!IN_READY && OUT_READY |=> IN_READY)
      else $error("ready not restored after drain");
   a_first_out: assert property (take |=> OUT_VALID)
      else $error("pixel not presented next cycle");
   a_bypass_pass: assert property (take && (ctrl_q == 6'h14 || ctrl_q == 6'h38)
      |=> OUT_PIXEL == $past(IN_PIXEL))
      else $error("bypass pixel changed");
   a_mono_equal: assert property (take && ctrl_q == 6'h04
      |=> OUT_PIXEL.c0 == OUT_PIXEL.c1 && OUT_PIXEL.c1 == OUT_PIXEL.c2)
      else $error("mono components differ");
   cover property (take);
   cover property (!IN_READY);
   cover property ($past(REG_RD) && REG_RDATA != 32'h0);
endmodule : pcc_convert_lut_monitor

bind pcc_convert_lut pcc_convert_lut_monitor u_mon (.CLK, .ARST_N, .REG_ADDR, .REG_WDATA,
   .REG_WR, .REG_RD, .REG_RDATA, .IN_VALID, .IN_READY, .IN_PIXEL, .OUT_VALID, .OUT_READY,
   .OUT_PIXEL);

// ==== testbench/pcc_stream_partner.sv ====
/* Model of the de-mosaic source and the formatter sink.
   Assumes the bench fills txq, empties rxq and drives stall. */
module pcc_stream_partner
   import pcc_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       arst_n,
   // Source side
   output logic            in_valid,
   input  wire logic       in_ready,
   output pcc_pixel_t      in_pixel,
   // Sink side
   input  wire logic       out_valid,
   output logic            out_ready,
   input  wire pcc_pixel_t out_pixel,
   input  wire logic       stall
);
   timeunit 1ns;
   timeprecision 1ps;
   pcc_pixel_t txq[$];
   pcc_pixel_t rxq[$];
   assign out_ready = !stall;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         in_valid <= 1'b0;
         in_pixel <= '0;
      end else begin
         if (!in_valid || in_ready) begin
            in_valid <= txq.size() > 0;
            in_pixel <= txq.size() > 0 ? txq.pop_front() : ~in_pixel;
         end
         if (out_valid && out_ready)
            rxq.push_back(out_pixel);
      end
   end
endmodule : pcc_stream_partner

// ==== testbench/pcc_convert_lut_test.sv ====
/* Self-checking bench of the pixel convert and lookup block.
   Assumes the partner model on the stream; drives registers and loads. */
module pcc_convert_lut_test import pcc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, arst_n, reg_wr, reg_rd, in_valid, in_ready, out_valid, out_ready, stall;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   pcc_pixel_t  in_pixel, out_pixel;
   pcc_load_t   load;
   int          err_count = 0, n_tests = 0;
   always #5 clk = ~clk;
   pcc_convert_lut dut (.CLK(clk), .ARST_N(arst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
      .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .IN_VALID(in_valid),
      .IN_READY(in_ready), .IN_PIXEL(in_pixel), .OUT_VALID(out_valid), .OUT_READY(out_ready),
      .OUT_PIXEL(out_pixel), .LOAD(load));
   pcc_stream_partner peer (.clk, .arst_n, .in_valid, .in_ready, .in_pixel, .out_valid,
      .out_ready, .out_pixel, .stall);
   task automatic chk(input logic [47:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask : rd
   task automatic ld(input logic s, input logic [15:0] d);
      @(posedge clk);
      load <= {1'b1, s, 2'h1, 14'h1234, d};
      @(posedge clk);
      load <= '0;
   endtask : ld
   task automatic px(input pcc_pixel_t p, e);
      int n;
      peer.txq.push_back(p);
      for (n = 0; n < 50 && peer.rxq.size() == 0; n++)
         @(posedge clk);
      #1 chk(peer.rxq.size() > 0 ? peer.rxq.pop_front() : ~e, e);
   endtask : px
   task automatic t_reset;
      rd(PCC_OFF_CTRL, 32'h14);
      rd(PCC_OFF_RED_VAL, 32'h0);
      rd(8'h40, 32'h0);
   endtask : t_reset
   task automatic t_stream;
      int k;
      @(posedge clk);
      stall <= 1'b1;
      for (k = 1; k < 4; k++)
         peer.txq.push_back({3{16'(k)}});
      repeat (6) @(posedge clk);
      #1 chk(in_ready, 1'b0);
      rd(PCC_OFF_STATUS, 32'h0002_0002);
      @(posedge clk);
      stall <= 1'b0;
      repeat (8) @(posedge clk);
      chk(48'(peer.rxq.size()), 48'h3);
      for (k = 1; k < 4; k++)
         chk(peer.rxq.pop_front(), {3{16'(k)}});
      rd(PCC_OFF_STATUS, 32'h0003_0000);
   endtask : t_stream
   task automatic t_convert;
      logic [7:0] uc[6] = '{8'h00, 8'h18, 8'h28, 8'h3c, 8'h38, 8'h2c};
      foreach (uc[i]) begin
         wr(PCC_OFF_CTRL, 32'(uc[i]));
         px({16'h9, 16'h8, 16'h7}, {16'h9, 16'h8, 16'h7});
      end
      wr(PCC_OFF_CTRL, 32'h10);
      px({16'h9, 16'h8, 16'h7}, {3{16'h7}});
      wr(PCC_OFF_CTRL, 32'h04);
      px({16'hc, 16'h8, 16'h4}, {3{16'h8}});
      wr(PCC_OFF_CTRL, 32'h08);
      px({16'hc, 16'h8, 16'h4}, {3{16'h8}});
   endtask : t_convert
   task automatic t_tables;
      int k;
      wr(PCC_OFF_GEN_IDX, 32'h5);
      wr(PCC_OFF_GEN_VAL, 32'hbeef);
      rd(PCC_OFF_BLU_VAL, 32'hbeef);
      rd(PCC_OFF_GEN_IDX, 32'h5);
      for (k = 0; k < 3; k++) begin
         wr(8'(4 + 8 * k), 32'h1234);
         wr(8'(8 + 8 * k), 32'(16'h1111 * (k + 1)));
         rd(8'(8 + 8 * k), 32'(16'h1111 * (k + 1)));
      end
      wr(PCC_OFF_CTRL, 32'h15);
      px({3{16'h48d3}}, {16'h3333, 16'h2222, 16'h1111});
      wr(PCC_OFF_RED_IDX, 32'hffff_ffff);
      rd(PCC_OFF_RED_IDX, 32'h3fff);
      rd(PCC_OFF_RED_VAL, 32'h0);
   endtask : t_tables
   task automatic t_load;
      ld(1'b0, 16'haaaa);
      rd(PCC_OFF_GRN_VAL, 32'haaaa);
      ld(1'b1, 16'h5555);
      rd(PCC_OFF_GRN_VAL, 32'haaaa);
      wr(PCC_OFF_CTRL, 32'h17);
      ld(1'b1, 16'h5555);
      rd(PCC_OFF_GRN_VAL, 32'h5555);
      wr(PCC_OFF_GRN_VAL, 32'h7777);
      ld(1'b0, 16'h0001);
      rd(PCC_OFF_GRN_VAL, 32'h7777);
      px({3{16'h48d3}}, {16'h3333, 16'h7777, 16'h1111});
   endtask : t_load
   task automatic end_of_test;
      $display("checks %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_of_test
   initial begin
      {clk, arst_n, reg_wr, reg_rd, stall} = '0;
      reg_addr = '0;
      reg_wdata = '0;
      load = '0;
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      t_reset;
      t_stream;
      t_convert;
      t_tables;
      t_load;
      end_of_test;
   end
   initial begin
      #100us;
      err_count++;
      end_of_test;
   end
endmodule : pcc_convert_lut_test
